// >>> verilog/isa_bus_cfg.svh
`ifndef ISA_BUS_CFG_SVH
`define ISA_BUS_CFG_SVH

// ==========================================================================
// Timing
`define CLK_PERIOD_NS    8
`define RST_MIN_NS       800
`define RST_MIN_CYC      ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W        8

// ==========================================================================
// Widths
`define IRQ_LINES        8
`define IRQ_SEL_W        3
`define SA_W             20
`define SD_W             16
`define SYNC_W           51

// ==========================================================================
// Decode constants
`define PNP_ADDR_PORT    12'h279
`define PNP_DATA_PORT    12'hA79
`define IO_DATA_OFS      5'h10
`define IRQ_ONE          8'h01
`define IO_ZERO10        10'h000
`define RST_CNT_ONE      8'h01

`endif

// >>> verilog/isa_bus_pkg.sv
package isa_bus_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_HOLD = 2'b10
  } acc_state_e;

  typedef enum logic [2:0] {
    ACC_IO_RD    = 3'b000,
    ACC_IO_WR    = 3'b001,
    ACC_MEM_RD   = 3'b010,
    ACC_MEM_WR   = 3'b011,
    ACC_PNP_ADDR = 3'b100,
    ACC_PNP_DATA = 3'b101
  } acc_kind_e;

endpackage : isa_bus_pkg

// >>> verilog/isa_pin_sync.sv
`timescale 1ns/1ns

module isa_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Pins and filtered result
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  // ========================================================================
  // Three stages; a bit moves once stages two and three agree
  always_comb begin
    state_next    = state_reg;
    state_next.s1 = pin_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.q[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_q = state_reg.q;

endmodule : isa_pin_sync

// >>> verilog/isa_host_bus_interface.sv
`timescale 1ns/1ns
`include "isa_bus_cfg.svh"

// Functional notes
// - I/O commands count only with address enable low
// - Eight request outputs map to lines 15..2/9
// - Exactly one request output driven, others released
// - All eight lines sampled into readable status
// - Channel ready pulled low until I/O or memory access completes
// - Slot width sensed at bus reset fall
// - Sense pin then open-drain 16-bit select
// - 16-bit select decoded combinationally from pins
// - Bus reset high; pulses under 800ns ignored
// - Config ports decoded on 12 address bits, bit 10 zero
// - Memory write strobe decodes flash writes
module isa_host_bus_interface (
  // Clock and power-on reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Host command pins
  input  wire logic                    aen,
  input  wire logic [`SA_W-1:0]        sa,
  input  wire logic                    ior_n,
  input  wire logic                    iow_n,
  input  wire logic                    smemr_n,
  input  wire logic                    smemw_n,
  input  wire logic                    bus_reset,
  // Host data bus
  input  wire logic [`SD_W-1:0]        sd_in,
  output logic      [`SD_W-1:0]        sd_out,
  output logic                         sd_oe,
  // Channel ready, open drain
  output logic                         chrdy_out,
  output logic                         chrdy_oe,
  // Slot width sense and 16-bit select, open drain
  input  wire logic                    slot_width_sense_in,
  output logic                         slot_width_sense_out,
  output logic                         slot_width_sense_oe,
  // Interrupt lines
  input  wire logic [`IRQ_LINES-1:0]   interrupt_line_monitor,
  output logic      [`IRQ_LINES-1:0]   interrupt_request_outputs,
  output logic      [`IRQ_LINES-1:0]   interrupt_request_oe,
  // Configuration from the core
  input  wire logic [9:0]              io_base,
  input  wire logic [5:0]              rom_base,
  input  wire logic                    flash_write_enable,
  input  wire logic [`IRQ_SEL_W-1:0]   irq_select,
  input  wire logic                    irq_request,
  // Access handshake with the core
  output logic                         acc_req,
  output isa_bus_pkg::acc_kind_e       acc_kind,
  output logic      [13:0]             acc_addr,
  output logic      [`SD_W-1:0]        acc_wdata,
  input  wire logic                    core_ready,
  input  wire logic [`SD_W-1:0]        core_rdata,
  // Status to the core
  output logic      [`IRQ_LINES-1:0]   irq_line_status,
  output logic                         slot_is_16,
  output logic                         core_reset
);

  typedef struct packed {
    isa_bus_pkg::acc_state_e   st;
    isa_bus_pkg::acc_kind_e    kind;
    logic                      req;
    logic [13:0]               addr;
    logic [`SD_W-1:0]          wdata;
    logic [`SD_W-1:0]          rdata;
    logic [`RST_CNT_W-1:0]     rst_cnt;
    logic                      bus_rst;
    logic                      sense_done;
    logic                      slot_width_sense;
    logic [`IRQ_SEL_W-1:0]     irq_sel;
    logic                      irq_lvl;
    logic [`IRQ_LINES-1:0]     irq_status;
  } ctl_s;

  ctl_s state_reg;
  ctl_s state_next;

  // ========================================================================
  // Decode functions
  function automatic logic io_window_hit(input logic [9:0] a, input logic [9:0] base);
    io_window_hit = (a[9:5] == base[9:5]);
  endfunction : io_window_hit

  function automatic logic pnp_port_hit(input logic [11:0] a);
    pnp_port_hit = (a == `PNP_ADDR_PORT) || (a == `PNP_DATA_PORT);
  endfunction : pnp_port_hit

  // ========================================================================
  // Pin synchronisation
  logic                    aen_s;
  logic [`SA_W-1:0]        sa_s;
  logic                    ior_n_s;
  logic                    iow_n_s;
  logic                    smemr_n_s;
  logic                    smemw_n_s;
  logic                    rst_s;
  logic                    sense_s;
  logic [`SD_W-1:0]        sd_s;
  logic [`IRQ_LINES-1:0]   irq_s;
  logic [`SYNC_W-1:0]      sync_q;

  isa_pin_sync #(.W(`SYNC_W)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin_in ({aen, sa, ior_n, iow_n, smemr_n, smemw_n, bus_reset,
              slot_width_sense_in, sd_in, interrupt_line_monitor}),
    .pin_q  (sync_q)
  );

  assign {aen_s, sa_s, ior_n_s, iow_n_s, smemr_n_s, smemw_n_s, rst_s,
          sense_s, sd_s, irq_s} = sync_q;

  // ========================================================================
  // Command qualification
  logic io_q;
  logic pnp_q;
  logic mem_q;
  logic strobes_idle;
  logic is_read;
  logic read_strobe;

  assign io_q         = !aen_s && io_window_hit(sa_s[9:0], io_base);
  assign pnp_q        = !aen_s && pnp_port_hit(sa_s[11:0]);
  assign mem_q        = (sa_s[19:14] == rom_base);
  assign strobes_idle = ior_n_s && iow_n_s && smemr_n_s && smemw_n_s;
  assign is_read      = (state_reg.kind == isa_bus_pkg::ACC_IO_RD) ||
                        (state_reg.kind == isa_bus_pkg::ACC_MEM_RD);
  assign read_strobe  = (state_reg.kind == isa_bus_pkg::ACC_IO_RD) ? !ior_n_s : !smemr_n_s;

  // ========================================================================
  // Next state
  always_comb begin
    state_next         = state_reg;
    state_next.req     = 1'b0;
    state_next.irq_sel = irq_select;
    state_next.irq_lvl = irq_request;
    state_next.irq_status = irq_s;

    // Bus reset filter and slot sensing
    if (rst_s) begin
      if (state_reg.rst_cnt != `RST_CNT_W'(`RST_MIN_CYC)) begin
        state_next.rst_cnt = state_reg.rst_cnt + `RST_CNT_ONE;
      end
      if (state_reg.rst_cnt == `RST_CNT_W'(`RST_MIN_CYC - 1)) begin
        state_next.bus_rst    = 1'b1;
        state_next.sense_done = 1'b0;
      end
    end else begin
      state_next.rst_cnt = '0;
      if (state_reg.bus_rst) begin
        state_next.bus_rst    = 1'b0;
        state_next.slot_width_sense     = sense_s;
        state_next.sense_done = 1'b1;
      end
    end

    // Access sequencer
    if (state_reg.bus_rst) begin
      state_next.st = isa_bus_pkg::ST_IDLE;
    end else begin
      unique case (state_reg.st)
        isa_bus_pkg::ST_IDLE: begin
          state_next.wdata = sd_s;
          if (!ior_n_s && io_q) begin
            state_next.kind = isa_bus_pkg::ACC_IO_RD;
            state_next.addr = {9'h000, sa_s[4:0]};
            state_next.req  = 1'b1;
            state_next.st   = isa_bus_pkg::ST_WAIT;
          end else if (!iow_n_s && pnp_q) begin
            state_next.kind = sa_s[11] ? isa_bus_pkg::ACC_PNP_DATA
                                       : isa_bus_pkg::ACC_PNP_ADDR;
            state_next.addr = {2'h0, sa_s[11:0]};
            state_next.req  = 1'b1;
            state_next.st   = isa_bus_pkg::ST_HOLD;
          end else if (!iow_n_s && io_q) begin
            state_next.kind = isa_bus_pkg::ACC_IO_WR;
            state_next.addr = {9'h000, sa_s[4:0]};
            state_next.req  = 1'b1;
            state_next.st   = isa_bus_pkg::ST_WAIT;
          end else if (!smemr_n_s && mem_q) begin
            state_next.kind = isa_bus_pkg::ACC_MEM_RD;
            state_next.addr = sa_s[13:0];
            state_next.req  = 1'b1;
            state_next.st   = isa_bus_pkg::ST_WAIT;
          end else if (!smemw_n_s && mem_q && flash_write_enable) begin
            state_next.kind = isa_bus_pkg::ACC_MEM_WR;
            state_next.addr = sa_s[13:0];
            state_next.req  = 1'b1;
            state_next.st   = isa_bus_pkg::ST_WAIT;
          end
        end
        isa_bus_pkg::ST_WAIT: begin
          if (core_ready) begin
            state_next.rdata = core_rdata;
            state_next.st    = isa_bus_pkg::ST_HOLD;
          end
        end
        isa_bus_pkg::ST_HOLD: begin
          if (strobes_idle) begin
            state_next.st = isa_bus_pkg::ST_IDLE;
          end
        end
        default: begin
          state_next.st = isa_bus_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= '0;
      state_reg.st   <= isa_bus_pkg::ST_IDLE;
      state_reg.kind <= isa_bus_pkg::ACC_IO_RD;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Pin drivers
  assign sd_out    = state_reg.rdata;
  assign sd_oe     = is_read && (state_reg.st != isa_bus_pkg::ST_IDLE) && read_strobe;
  assign chrdy_out = 1'b0;
  assign chrdy_oe  = (state_reg.st == isa_bus_pkg::ST_WAIT);

  // Select covers the data port, offsets 10h to 17h of the I/O window
  logic [4:0] sel_ofs;
  assign sel_ofs = `IO_DATA_OFS;

  assign slot_width_sense_out = 1'b0;
  assign slot_width_sense_oe  = state_reg.sense_done && state_reg.slot_width_sense && !aen &&
                                io_window_hit(sa[9:0], io_base) &&
                                (sa[4:3] == sel_ofs[4:3]);

  assign interrupt_request_oe      = `IRQ_ONE << state_reg.irq_sel;
  assign interrupt_request_outputs = {`IRQ_LINES{state_reg.irq_lvl}};

  assign acc_req         = state_reg.req;
  assign acc_kind        = state_reg.kind;
  assign acc_addr        = state_reg.addr;
  assign acc_wdata       = state_reg.wdata;
  assign irq_line_status = state_reg.irq_status;
  assign slot_is_16      = state_reg.slot_width_sense;
  assign core_reset      = state_reg.bus_rst;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_AEN_BLOCKS_IO: assert property (
    acc_req && (acc_kind inside {isa_bus_pkg::ACC_IO_RD, isa_bus_pkg::ACC_IO_WR})
      |-> $past(!aen_s)) else $error("io access taken with address enable high");
  AST_IRQ_MAP: assert property (
    ##1 interrupt_request_oe == (`IRQ_ONE << $past(irq_select)))
    else $error("request output does not follow selection");
  AST_IRQ_ONEHOT: assert property (
    $onehot(interrupt_request_oe)) else $error("request drive is not one-hot");
  AST_IRQ_STATUS: assert property (
    ##1 irq_line_status == $past(irq_s)) else $error("line status lags wrongly");
  AST_CHRDY_WAIT: assert property (
    acc_req && (acc_kind != isa_bus_pkg::ACC_PNP_ADDR) &&
      (acc_kind != isa_bus_pkg::ACC_PNP_DATA) |-> chrdy_oe)
    else $error("access started without wait");
  AST_CHRDY_RELEASE: assert property (
    chrdy_oe && core_ready |=> !chrdy_oe) else $error("ready not released");
  AST_SLOT_LATCH: assert property (
    $fell(core_reset) |-> slot_is_16 == $past(sense_s))
    else $error("slot width not latched at reset fall");
  AST_IO16_DECODE: assert property (
    slot_width_sense_oe |-> slot_is_16 && !aen && !core_reset)
    else $error("16-bit select driven wrongly");
  AST_RST_FILTER: assert property (
    $rose(core_reset) |-> $past(state_reg.rst_cnt) == `RST_CNT_W'(`RST_MIN_CYC - 1))
    else $error("bus reset accepted too early");
  AST_PNP_DECODE: assert property (
    acc_req && (acc_kind inside {isa_bus_pkg::ACC_PNP_ADDR, isa_bus_pkg::ACC_PNP_DATA})
      |-> $past(sa_s[10] == 1'b0 && !aen_s)) else $error("config port decode wrong");
  AST_MEM_WRITE: assert property (
    acc_req && (acc_kind == isa_bus_pkg::ACC_MEM_WR)
      |-> $past(!smemw_n_s && flash_write_enable)) else $error("flash write not qualified");
  AST_SD_DRIVE: assert property (
    sd_oe |-> (acc_kind inside {isa_bus_pkg::ACC_IO_RD, isa_bus_pkg::ACC_MEM_RD}) &&
      (!ior_n_s || !smemr_n_s)) else $error("data bus driven outside read");
  AST_IRQ_LEVEL: assert property (
    ##1 interrupt_request_outputs == {`IRQ_LINES{$past(irq_request)}})
    else $error("request level does not follow core");
  AST_RST_QUIET: assert property (
    core_reset |=> !chrdy_oe && !acc_req) else $error("access during bus reset");
  AST_MEM_WINDOW: assert property (
    acc_req && (acc_kind inside {isa_bus_pkg::ACC_MEM_RD, isa_bus_pkg::ACC_MEM_WR})
      |-> $past(sa_s[19:14] == rom_base)) else $error("memory access outside window");
  AST_PNP_NO_WAIT: assert property (
    acc_req && (acc_kind inside {isa_bus_pkg::ACC_PNP_ADDR, isa_bus_pkg::ACC_PNP_DATA})
      |-> !chrdy_oe) else $error("config port access stretched");
  AST_REQ_PULSE: assert property (
    acc_req |=> !acc_req) else $error("access request longer than one cycle");
  AST_IO16_QUIET: assert property (
    !slot_is_16 |-> !slot_width_sense_oe) else $error("16-bit select in 8-bit slot");

  COV_IO_READ:  cover property (acc_req && acc_kind == isa_bus_pkg::ACC_IO_RD ##[1:20] sd_oe);
  COV_MEM_WR:   cover property (acc_req && acc_kind == isa_bus_pkg::ACC_MEM_WR);
  COV_PNP_WR:   cover property (acc_req && acc_kind == isa_bus_pkg::ACC_PNP_DATA);
  COV_BUS_RST:  cover property ($fell(core_reset) ##1 slot_is_16);
  COV_IO16_SEL: cover property (slot_width_sense_oe && !aen);

endmodule : isa_host_bus_interface

// >>> verification/isa_host_model.sv
`timescale 1ns/1ns
`include "isa_bus_cfg.svh"

// ==========================================================================
// Host bus controller on the far side of the slot
module isa_host_model (
  // Clock
  input  wire logic             clk,
  // Command pins
  output logic                  aen,
  output logic [`SA_W-1:0]      sa,
  output logic                  ior_n,
  output logic                  iow_n,
  output logic                  smemr_n,
  output logic                  smemw_n,
  output logic                  bus_reset,
  // Data bus and channel ready
  output logic [`SD_W-1:0]      sd_in,
  input  wire logic [`SD_W-1:0] sd_out,
  input  wire logic             sd_oe,
  input  wire logic             chrdy_out,
  input  wire logic             chrdy_oe
);
  logic [`SD_W-1:0] wr_val;
  logic             chrdy_wire;

  initial begin
    aen = 1'b1;
    sa = '0;
    {ior_n, iow_n, smemr_n, smemw_n} = 4'hF;
    bus_reset = 1'b0;
    wr_val = '0;
  end

  // Ready is pulled up on the board; a released data bus shows the inverse of wr_val, which every cycle sets to its data value
  assign chrdy_wire = chrdy_oe ? chrdy_out : 1'b1;
  always_comb sd_in = (!iow_n || !smemw_n) ? wr_val : (sd_oe ? sd_out : ~wr_val);

  task automatic set_addr(input logic av, input logic [`SA_W-1:0] a);
    @(posedge clk);
    aen <= av;
    sa <= a;
  endtask : set_addr

  // s: 0 I/O read, 1 I/O write, 2 memory read, 3 memory write
  task automatic cycle(input int s, input logic av, input logic [`SA_W-1:0] a,
                       input logic [`SD_W-1:0] d, output logic [`SD_W-1:0] rd);
    int n;
    set_addr(av, a);
    wr_val <= d;
    @(posedge clk);
    ior_n <= (s != 0);
    iow_n <= (s != 1);
    smemr_n <= (s != 2);
    smemw_n <= (s != 3);
    repeat (6) @(posedge clk);
    n = 0;
    while (chrdy_wire !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    rd = sd_in;
    {ior_n, iow_n, smemr_n, smemw_n} <= 4'hF;
    repeat (6) @(posedge clk);
    aen <= 1'b1;
  endtask : cycle

  task automatic reset_pulse(input int n);
    @(posedge clk);
    bus_reset <= 1'b1;
    repeat (n) @(posedge clk);
    bus_reset <= 1'b0;
  endtask : reset_pulse
endmodule : isa_host_model

// >>> verification/testbench.sv
`timescale 1ns/1ns
`include "isa_bus_cfg.svh"

module testbench;
  typedef struct packed {
    logic [2:0]       kind;
    logic [13:0]      addr;
    logic [`SD_W-1:0] data;
    logic             wr;
  } note_s;

  logic                   clk = 1'b0;
  logic                   resetn, aen, ior_n, iow_n, smemr_n, smemw_n, bus_reset;
  logic [`SA_W-1:0]       sa;
  logic [`SD_W-1:0]       sd_in, sd_out, core_rdata, acc_wdata, rdata_exp;
  logic                   sd_oe, chrdy_out, chrdy_oe, core_ready, acc_req, irq_request;
  logic                   slot_pull, slot_pin, slot_out, slot_oe, slot_is_16, core_reset;
  logic [`IRQ_LINES-1:0]  irq_pull, irq_wire, irq_out, irq_oe, irq_status;
  logic [9:0]             io_base;
  logic [5:0]             rom_base;
  logic                   flash_write_enable;
  logic [`IRQ_SEL_W-1:0]  irq_select;
  isa_bus_pkg::acc_kind_e acc_kind;
  logic [13:0]            acc_addr;
  logic [31:0]            seed = 32'h0000CDE0;
  logic [31:0]            r;
  note_s                  notes[$];
  note_s                  nt;
  int                     fails = 0;
  int                     checked = 0;

  always #4 clk = ~clk;

  // Resolved open-drain and tri-state lines
  assign slot_pin = slot_oe ? 1'b0 : slot_pull;
  assign irq_wire = (irq_oe & irq_out) | (~irq_oe & irq_pull);

  isa_host_bus_interface i_isa_host_bus_interface (
    .clk(clk), .resetn(resetn), .aen(aen), .sa(sa), .ior_n(ior_n), .iow_n(iow_n),
    .smemr_n(smemr_n), .smemw_n(smemw_n), .bus_reset(bus_reset), .sd_in(sd_in),
    .sd_out(sd_out), .sd_oe(sd_oe), .chrdy_out(chrdy_out), .chrdy_oe(chrdy_oe),
    .slot_width_sense_in(slot_pin), .slot_width_sense_out(slot_out),
    .slot_width_sense_oe(slot_oe), .interrupt_line_monitor(irq_wire),
    .interrupt_request_outputs(irq_out), .interrupt_request_oe(irq_oe),
    .io_base(io_base), .rom_base(rom_base), .flash_write_enable(flash_write_enable),
    .irq_select(irq_select), .irq_request(irq_request), .acc_req(acc_req),
    .acc_kind(acc_kind), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .core_ready(core_ready), .core_rdata(core_rdata), .irq_line_status(irq_status),
    .slot_is_16(slot_is_16), .core_reset(core_reset));

  isa_host_model i_isa_host_model (
    .clk(clk), .aen(aen), .sa(sa), .ior_n(ior_n), .iow_n(iow_n), .smemr_n(smemr_n),
    .smemw_n(smemw_n), .bus_reset(bus_reset), .sd_in(sd_in), .sd_out(sd_out),
    .sd_oe(sd_oe), .chrdy_out(chrdy_out), .chrdy_oe(chrdy_oe));

  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xrand

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic probe(input logic av, input logic [`SA_W-1:0] a, input logic exp);
    i_isa_host_model.set_addr(av, a);
    #1;
    check("16-bit select", slot_oe, exp);
    check("select level", slot_out, 0);
  endtask : probe

  task automatic run(input int s, input logic av, input logic [`SA_W-1:0] a, input logic ok,
                     input logic [2:0] k, input logic [13:0] ea);
    logic [`SD_W-1:0] rd;
    r = xrand();
    rdata_exp = r[31:16];
    if (ok) notes.push_back('{k, ea, r[15:0], s[0]});
    i_isa_host_model.cycle(s, av, a, r[15:0], rd);
    if (ok && !s[0]) check("read data", rd, rdata_exp);
    check("sd_oe released", sd_oe, 0);
  endtask : run

  // ==========================================================================
  // Result watcher: every accepted access must match the oldest note
  always @(posedge clk) begin
    if (acc_req === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected access", 1, 0);
      end else begin
        nt = notes.pop_front();
        check("acc_kind", acc_kind, nt.kind);
        check("acc_addr", acc_addr, nt.addr);
        check("chrdy_oe", chrdy_oe, !nt.kind[2]);
        if (nt.wr) check("acc_wdata", acc_wdata, nt.data);
      end
    end
  end

  // Core answers after 0..3 cycles
  initial begin
    core_ready = 1'b0;
    core_rdata = '0;
    forever begin
      @(posedge clk);
      if (acc_req === 1'b1 && acc_kind[2] === 1'b0) begin
        repeat (seed[1:0]) @(posedge clk);
        core_rdata <= rdata_exp;
        core_ready <= 1'b1;
        @(posedge clk);
        core_ready <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    slot_pull = 1'b0;
    irq_pull = 8'h00;
    io_base = 10'h300;
    rom_base = 6'h32;
    flash_write_enable = 1'b0;
    irq_select = 3'h0;
    irq_request = 1'b0;
    rdata_exp = 16'h0000;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    i_isa_host_model.reset_pulse(90);
    repeat (8) @(posedge clk);
    check("short bus reset", core_reset, 0);
    i_isa_host_model.reset_pulse(120);
    check("long bus reset", core_reset, 1);
    repeat (8) @(posedge clk);
    check("core_reset fall", core_reset, 0);
    check("slot 8-bit", slot_is_16, 0);
    probe(0, 20'h00310, 0);
    slot_pull <= 1'b1;
    i_isa_host_model.reset_pulse(120);
    repeat (8) @(posedge clk);
    check("slot 16-bit", slot_is_16, 1);
    probe(0, 20'h00310, 1);
    probe(0, 20'h00308, 0);
    probe(1, 20'h00310, 0);
    run(0, 0, 20'h00310, 1, isa_bus_pkg::ACC_IO_RD, 14'h0010);
    run(1, 0, 20'h00305, 1, isa_bus_pkg::ACC_IO_WR, 14'h0005);
    run(1, 1, 20'h00305, 0, isa_bus_pkg::ACC_IO_WR, 14'h0005);
    run(0, 1, 20'h00310, 0, isa_bus_pkg::ACC_IO_RD, 14'h0010);
    run(1, 0, 20'h00279, 1, isa_bus_pkg::ACC_PNP_ADDR, 14'h0279);
    run(1, 0, 20'h00A79, 1, isa_bus_pkg::ACC_PNP_DATA, 14'h0A79);
    run(1, 0, 20'h00679, 0, isa_bus_pkg::ACC_PNP_ADDR, 14'h0679);
    run(2, 0, 20'hC8123, 1, isa_bus_pkg::ACC_MEM_RD, 14'h0123);
    run(3, 0, 20'hC8456, 0, isa_bus_pkg::ACC_MEM_WR, 14'h0456);
    flash_write_enable <= 1'b1;
    run(3, 0, 20'hC8456, 1, isa_bus_pkg::ACC_MEM_WR, 14'h0456);
    for (int i = 0; i < `IRQ_LINES; i++) begin
      r = xrand();
      irq_select <= i[`IRQ_SEL_W-1:0];
      irq_request <= r[8];
      irq_pull <= r[7:0];
      repeat (8) @(posedge clk);
      check("irq enable", irq_oe, 8'h01 << i);
      check("irq level", irq_out, {8{irq_request}});
      check("irq status", irq_status, irq_wire);
    end
    check("pending notes", notes.size(), 0);
    summarize();
  end

  // Run needs about 600 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule : testbench
